/* rtl/byte_datapath.v */
// configurable 8-bit datapath tile with config ram, alu, compares, fifos
// assumes a synchronous register port and a fabric on core_clk_in
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "byte_datapath_defines.vh"
// What this block does
// - eight sixteen-bit configuration words define each cycle
// - fabric address selects configuration every cycle
// - alu offers inc dec add sub and or xor pass
// - optional shift left, right, swap, or mask
// - two maskable compares over accumulators, data registers
// - zero, ones, overflow conditions selectable to outputs
// - programmable most significant bit position
// - one crc or prs step per cycle
// - two four-byte fifos, each direction configurable
// - fifo zero status selectable as tile outputs
// - carry, shift, condition chaining with neighbours
// - registered carry and shift out reusable later
// - six fabric inputs and six fabric outputs
// - bus-written control register drives fabric
// - read-only status shows routed internal signals
// - sticky status bits cleared by software read
// - per sub-block clock enable control
// - eight-bit alu, one operation per cycle
// - two accumulators, two data registers as sources
module byte_datapath (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire [4:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [15:0] reg_rdata_out,
    input wire [5:0] fabric_in,
    output reg [5:0] fabric_out,
    input wire chain_carry_in,
    input wire chain_shift_in,
    input wire chain_cond_in,
    output reg chain_carry_out,
    output reg chain_shift_out,
    output reg chain_cond_out,
    output reg [7:0] ctrl_out
);
    // ********************************************
    // helpers
    // ********************************************
    // mask of bits at or below the chosen msb
    function [7:0] width_mask;
        input [2:0] msb;
        begin
            width_mask = 8'hff >> (3'h7 - msb);
        end
    endfunction
    // operand pick: 0 acc0, 1 acc1, 2 data0, 3 data1
    function [7:0] pick;
        input [1:0] sel;
        input [7:0] a0, a1, d0, d1;
        begin
            case (sel)
                2'h0: pick = a0;
                2'h1: pick = a1;
                2'h2: pick = d0;
                default: pick = d1;
            endcase
        end
    endfunction
    // ********************************************
    // state
    // ********************************************
    reg [15:0] cfg_q [0:7];
    reg [7:0] accumulator_zero_q, accumulator_one_q, data_reg_zero_q, data_reg_one_q;
    reg [2:0] msb_q;
    reg [7:0] mask_q, poly_q, cmp_mask0_q, cmp_mask1_q, ctrl_q, sticky_q;
    reg [1:0] fifo_dir_q;
    reg [17:0] out_sel_q;
    reg [1:0] clk_en_q;
    reg carry_q, shift_q;
    reg [5:0] fab_s1_q, fab_s2_q;
    reg ci_s1_q, ci_s2_q, si_s1_q, si_s2_q, cc_s1_q, cc_s2_q;
    integer i;
    // two-flop synchronisers on everything arriving from the fabric
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fab_s1_q <= 6'h00;
            fab_s2_q <= 6'h00;
            {ci_s1_q, ci_s2_q, si_s1_q, si_s2_q, cc_s1_q, cc_s2_q} <= 6'h00;
        end else begin
            fab_s1_q <= fabric_in;
            fab_s2_q <= fab_s1_q;
            ci_s1_q <= chain_carry_in;
            ci_s2_q <= ci_s1_q;
            si_s1_q <= chain_shift_in;
            si_s2_q <= si_s1_q;
            cc_s1_q <= chain_cond_in;
            cc_s2_q <= cc_s1_q;
        end
    end
    // ********************************************
    // cycle configuration and alu
    // ********************************************
    wire [15:0] cw = cfg_q[fab_s2_q[2:0]];
    wire [2:0] op = cw[`CW_OP_HI:`CW_OP_LO];
    wire dp_en = clk_en_q[0];
    wire [7:0] wm = width_mask(msb_q);
    wire [7:0] opa = cw[`CW_SRCA] ? accumulator_one_q : accumulator_zero_q;
    wire [7:0] opb = pick(cw[`CW_SRCB_HI:`CW_SRCB_LO], accumulator_zero_q,
        accumulator_one_q, data_reg_zero_q, data_reg_one_q);
    reg cin;
    reg [8:0] sum;
    reg [7:0] alu, shr, res;
    reg ovf, cout, sout, sin;
    // carry in: 0 none, 1 one, 2 registered, 3 chained
    always @* begin
        case (cw[`CW_CI_HI:`CW_CI_LO])
            2'h0: cin = 1'b0;
            2'h1: cin = 1'b1;
            2'h2: cin = carry_q;
            default: cin = ci_s2_q;
        endcase
        sin = fab_s2_q[3] | si_s2_q;
        sum = 9'h000;
        alu = opa;
        case (op)
            `OP_INC: sum = {1'b0, opa & wm} + 9'h001;
            `OP_DEC: sum = {1'b0, opa & wm} - 9'h001;
            `OP_ADD: sum = {1'b0, opa & wm} + {1'b0, opb & wm} + {8'h00, cin};
            `OP_SUB: sum = {1'b0, opa & wm} - {1'b0, opb & wm} - {8'h00, cin};
            `OP_AND: alu = opa & opb;
            `OP_OR: alu = opa | opb;
            `OP_XOR: alu = opa ^ opb;
            default: alu = opa;
        endcase
        if (op == `OP_INC || op == `OP_DEC || op == `OP_ADD || op == `OP_SUB) begin
            alu = sum[7:0];
        end
        // inc and add take carry at the programmed msb; dec and sub take borrow from sum bit 8
        cout = (op == `OP_INC || op == `OP_ADD) ? ((sum[8:0] >> msb_q) > 9'h001) : 1'b0;
        if (op == `OP_DEC || op == `OP_SUB) begin
            cout = sum[8];
        end
        ovf = (opa[msb_q] == opb[msb_q]) && (alu[msb_q] != opa[msb_q]);
        // crc/prs step: shift left within msb, feed back poly
        sout = alu[msb_q];
        case (cw[`CW_SH_HI:`CW_SH_LO])
            `SH_LEFT: shr = {alu[6:0], sin};
            `SH_RIGHT: begin
                shr = alu >> 1;
                shr[msb_q] = sin;
                sout = alu[0];
            end
            `SH_SWAP: shr = {alu[3:0], alu[7:4]};
            default: shr = alu;
        endcase
        if (cw[`CW_CRC]) begin
            shr = {alu[6:0], 1'b0} ^ ((alu[msb_q] ^ sin) ? poly_q : 8'h00);
        end
        res = (shr & wm) | (cw[`CW_CMASK] ? ~mask_q & wm : 8'h00);
    end
    // ********************************************
    // compares and conditions
    // ********************************************
    wire eq0 = ((accumulator_zero_q ^ data_reg_zero_q) & cmp_mask0_q) == 8'h00;
    wire lt0 = (accumulator_zero_q & cmp_mask0_q) < (data_reg_zero_q & cmp_mask0_q);
    wire eq1 = ((accumulator_one_q ^ data_reg_one_q) & cmp_mask1_q) == 8'h00 && cc_s2_q;
    wire zero0 = (accumulator_zero_q & wm) == 8'h00;
    wire ones0 = (accumulator_zero_q & wm) == wm;
    wire f0_full, f0_empty, f1_full, f1_empty;
    wire [7:0] f0_rdata, f1_rdata;
    wire [8:0] cond = {f1_empty, f1_full, f0_empty, f0_full, ovf, ones0, zero0, eq1,
        eq0 | lt0};
    wire [7:0] status = {cond[7:0]};
    // ********************************************
    // fifos
    // ********************************************
    wire bus_w0 = reg_wr_in && reg_addr_in == `ADR_FIFO0;
    wire bus_w1 = reg_wr_in && reg_addr_in == `ADR_FIFO1;
    wire bus_r0 = reg_rd_in && reg_addr_in == `ADR_FIFO0;
    wire bus_r1 = reg_rd_in && reg_addr_in == `ADR_FIFO1;
    wire in_w0 = dp_en && cw[`CW_F_WR];
    wire in_r0 = dp_en && cw[`CW_F_RD];
    // dir bit 1 = output buffer (tile writes, bus reads)
    byte_fifo4 u_fifo_zero (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .wr_in(fifo_dir_q[0] ? in_w0 : bus_w0),
        .wdata_in(fifo_dir_q[0] ? accumulator_zero_q : reg_wdata_in[7:0]),
        .rd_in(fifo_dir_q[0] ? bus_r0 : in_r0),
        .rdata_out(f0_rdata), .full_out(f0_full), .empty_out(f0_empty));
    byte_fifo4 u_fifo_one (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .wr_in(fifo_dir_q[1] ? in_w0 : bus_w1),
        .wdata_in(fifo_dir_q[1] ? accumulator_one_q : reg_wdata_in[7:0]),
        .rd_in(fifo_dir_q[1] ? bus_r1 : in_r0),
        .rdata_out(f1_rdata), .full_out(f1_full), .empty_out(f1_empty));
    // ********************************************
    // datapath registers and bus writes
    // ********************************************
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (i = 0; i < 8; i = i + 1) begin
                cfg_q[i] <= `RST_WORD;
            end
            accumulator_zero_q <= `RST_BYTE;
            accumulator_one_q <= `RST_BYTE;
            data_reg_zero_q <= `RST_BYTE;
            data_reg_one_q <= `RST_BYTE;
            msb_q <= `RST_MSB;
            mask_q <= `RST_MASK;
            poly_q <= `RST_BYTE;
            cmp_mask0_q <= `RST_MASK;
            cmp_mask1_q <= `RST_MASK;
            fifo_dir_q <= 2'h0;
            out_sel_q <= 18'h00000;
            ctrl_q <= `RST_BYTE;
            clk_en_q <= 2'h3;
            carry_q <= 1'b0;
            shift_q <= 1'b0;
        end else begin
            if (dp_en) begin
                carry_q <= cout;
                shift_q <= sout;
                case (cw[`CW_DST_HI:`CW_DST_LO])
                    2'h1: accumulator_zero_q <= res;
                    2'h2: accumulator_one_q <= res;
                    2'h3: accumulator_zero_q <= fifo_dir_q[0] ? accumulator_zero_q : f0_rdata;
                    default: accumulator_zero_q <= accumulator_zero_q;
                endcase
            end
            if (reg_wr_in) begin
                if (reg_addr_in < `ADR_MSB) begin
                    cfg_q[reg_addr_in[2:0]] <= reg_wdata_in;
                end else if (reg_addr_in == `ADR_MSB) begin
                    msb_q <= reg_wdata_in[2:0];
                end else if (reg_addr_in == `ADR_MASK) begin
                    mask_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_POLY) begin
                    poly_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_CMP_MASK0) begin
                    cmp_mask0_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_CMP_MASK1) begin
                    cmp_mask1_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_FIFO_DIR) begin
                    fifo_dir_q <= reg_wdata_in[1:0];
                end else if (reg_addr_in == `ADR_OUT_SEL) begin
                    out_sel_q <= {reg_wdata_in[1:0], reg_wdata_in};
                end else if (reg_addr_in == `ADR_CTRL) begin
                    ctrl_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_ACC0) begin
                    accumulator_zero_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_ACC1) begin
                    accumulator_one_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_DATA0) begin
                    data_reg_zero_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_DATA1) begin
                    data_reg_one_q <= reg_wdata_in[7:0];
                end else if (reg_addr_in == `ADR_CLK_EN) begin
                    clk_en_q <= reg_wdata_in[1:0];
                end
            end
        end
    end
    // ********************************************
    // sticky status, outputs and read port
    // ********************************************
    wire sticky_rd = reg_rd_in && reg_addr_in == `ADR_STICKY && clk_en_q[1];
    // set beats clear so a coinciding event survives the read
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sticky_q <= `RST_BYTE;
        end else if (clk_en_q[1]) begin
            sticky_q <= (sticky_rd ? 8'h00 : sticky_q) | status;
        end
    end
    // fabric outputs: three select bits per output, codes 0-6 pick a condition, 7 the shift flop
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fabric_out <= 6'h00;
            chain_carry_out <= 1'b0;
            chain_shift_out <= 1'b0;
            chain_cond_out <= 1'b0;
            ctrl_out <= `RST_BYTE;
            reg_rdata_out <= 16'h0000;
        end else begin
            for (i = 0; i < 6; i = i + 1) begin
                fabric_out[i] <= (out_sel_q[i*3 +: 3] == 3'h7) ? shift_q :
                    cond[out_sel_q[i*3 +: 3]];
            end
            chain_carry_out <= carry_q;
            chain_shift_out <= shift_q;
            chain_cond_out <= eq0;
            ctrl_out <= clk_en_q[1] ? ctrl_q : ctrl_out;
            reg_rdata_out <= 16'h0000;
            if (reg_rd_in) begin
                if (reg_addr_in < `ADR_MSB) begin
                    reg_rdata_out <= cfg_q[reg_addr_in[2:0]];
                end else if (reg_addr_in == `ADR_MSB) begin
                    reg_rdata_out <= {13'h0000, msb_q};
                end else if (reg_addr_in == `ADR_MASK) begin
                    reg_rdata_out <= {8'h00, mask_q};
                end else if (reg_addr_in == `ADR_CMP_MASK0) begin
                    reg_rdata_out <= {8'h00, cmp_mask0_q};
                end else if (reg_addr_in == `ADR_CMP_MASK1) begin
                    reg_rdata_out <= {8'h00, cmp_mask1_q};
                end else if (reg_addr_in == `ADR_DATA0) begin
                    reg_rdata_out <= {8'h00, data_reg_zero_q};
                end else if (reg_addr_in == `ADR_CLK_EN) begin
                    reg_rdata_out <= {14'h0000, clk_en_q};
                end else if (reg_addr_in == `ADR_CTRL) begin
                    reg_rdata_out <= {8'h00, ctrl_q};
                end else if (reg_addr_in == `ADR_STATUS) begin
                    reg_rdata_out <= {8'h00, status};
                end else if (reg_addr_in == `ADR_STICKY) begin
                    reg_rdata_out <= {8'h00, sticky_q};
                end else if (reg_addr_in == `ADR_FIFO0) begin
                    reg_rdata_out <= {8'h00, f0_rdata};
                end else if (reg_addr_in == `ADR_FIFO1) begin
                    reg_rdata_out <= {8'h00, f1_rdata};
                end else if (reg_addr_in == `ADR_ACC0) begin
                    reg_rdata_out <= {8'h00, accumulator_zero_q};
                end else if (reg_addr_in == `ADR_ACC1) begin
                    reg_rdata_out <= {8'h00, accumulator_one_q};
                end
            end
        end
    end
endmodule // byte_datapath
`default_nettype wire

/* rtl/byte_datapath_defines.vh */
// constants for the configurable byte datapath tile
// assumes inclusion by bare name from design files of the tile
`ifndef BYTE_DATAPATH_DEFINES_VH
`define BYTE_DATAPATH_DEFINES_VH
// ********************************************
// alu function codes
// ********************************************
`define OP_PASS 3'h0
`define OP_INC 3'h1
`define OP_DEC 3'h2
`define OP_ADD 3'h3
`define OP_SUB 3'h4
`define OP_AND 3'h5
`define OP_OR 3'h6
`define OP_XOR 3'h7
// ********************************************
// shift stage codes
// ********************************************
`define SH_NONE 2'h0
`define SH_LEFT 2'h1
`define SH_RIGHT 2'h2
`define SH_SWAP 2'h3
// ********************************************
// configuration word fields
// ********************************************
`define CW_OP_HI 2
`define CW_OP_LO 0
`define CW_SRCA 3
`define CW_SRCB_HI 5
`define CW_SRCB_LO 4
`define CW_SH_HI 7
`define CW_SH_LO 6
`define CW_DST_HI 9
`define CW_DST_LO 8
`define CW_CMASK 10
`define CW_CI_HI 12
`define CW_CI_LO 11
`define CW_CRC 13
`define CW_F_WR 14
`define CW_F_RD 15
// ********************************************
// register bus offsets
// ********************************************
`define ADR_CFG_BASE 5'h00
`define ADR_MSB 5'h08
`define ADR_MASK 5'h09
`define ADR_POLY 5'h0a
`define ADR_CMP_MASK0 5'h0b
`define ADR_CMP_MASK1 5'h0c
`define ADR_FIFO_DIR 5'h0d
`define ADR_OUT_SEL 5'h0e
`define ADR_CTRL 5'h0f
`define ADR_STATUS 5'h10
`define ADR_STICKY 5'h11
`define ADR_FIFO0 5'h12
`define ADR_FIFO1 5'h13
`define ADR_ACC0 5'h14
`define ADR_ACC1 5'h15
`define ADR_DATA0 5'h16
`define ADR_DATA1 5'h17
`define ADR_CLK_EN 5'h18
// ********************************************
// sizes and reset values
// ********************************************
`define FIFO_DEPTH 3'h4
`define RST_BYTE 8'h00
`define RST_MSB 3'h7
`define RST_MASK 8'hff
`define RST_WORD 16'h0000
`endif

/* rtl/byte_fifo4.v */
// four-byte flip-flop fifo used for both tile buffers
// assumes one clock and writers that respect full and empty
`timescale 1ns/100ps
`default_nettype none
`include "byte_datapath_defines.vh"
module byte_fifo4 (
    input wire core_clk_in,
    input wire arst_n_in,
    input wire wr_in,
    input wire [7:0] wdata_in,
    input wire rd_in,
    output wire [7:0] rdata_out,
    output wire full_out,
    output wire empty_out
);
    reg [7:0] mem_q [0:3];
    reg [1:0] wp_q;
    reg [1:0] rp_q;
    reg [2:0] cnt_q;
    wire do_wr;
    wire do_rd;
    // refuse silently on overflow or underflow so the count never lies
    assign do_wr = wr_in && (cnt_q != `FIFO_DEPTH);
    assign do_rd = rd_in && (cnt_q != 3'h0);
    assign full_out = (cnt_q == `FIFO_DEPTH);
    assign empty_out = (cnt_q == 3'h0);
    assign rdata_out = mem_q[rp_q];
    // pointer and storage update
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wp_q <= 2'h0;
            rp_q <= 2'h0;
            cnt_q <= 3'h0;
            mem_q[0] <= `RST_BYTE;
            mem_q[1] <= `RST_BYTE;
            mem_q[2] <= `RST_BYTE;
            mem_q[3] <= `RST_BYTE;
        end else begin
            if (do_wr) begin
                mem_q[wp_q] <= wdata_in;
                wp_q <= wp_q + 2'h1;
            end
            if (do_rd) begin
                rp_q <= rp_q + 2'h1;
            end
            if (do_wr && !do_rd) begin
                cnt_q <= cnt_q + 3'h1;
            end else if (do_rd && !do_wr) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
endmodule // byte_fifo4
`default_nettype wire

/* verification/byte_datapath_properties.sv */
// checker for the byte datapath register port and control output
// assumes binding onto byte_datapath, one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "byte_datapath_defines.vh"
module datapath_checker (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [7:0] ctrl_out
);
    // ********************************************
    // shadows of registers that only the bus writes
    // ********************************************
    logic [15:0] cfg_q [0:7];
    logic [7:0] data0_q;
    logic [7:0] mask_q;
    logic [7:0] ctrl_q;
    logic [1:0] clk_en_q;

    // shadows follow bus writes; internal updates never touch these
    always @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < 8; i++)
                cfg_q[i] <= 16'h0000;
            data0_q <= 8'h00;
            mask_q <= 8'hff;
            ctrl_q <= 8'h00;
            clk_en_q <= 2'h3;
        end else if (reg_wr_in) begin
            if (reg_addr_in < 5'h08)
                cfg_q[reg_addr_in[2:0]] <= reg_wdata_in;
            if (reg_addr_in == `ADR_DATA0)
                data0_q <= reg_wdata_in[7:0];
            if (reg_addr_in == `ADR_MASK)
                mask_q <= reg_wdata_in[7:0];
            if (reg_addr_in == `ADR_CTRL)
                ctrl_q <= reg_wdata_in[7:0];
            if (reg_addr_in == `ADR_CLK_EN)
                clk_en_q <= reg_wdata_in[1:0];
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    chk_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data seen without a read");
    chk_unmapped_zero: assert property (
        reg_rd_in && reg_addr_in > `ADR_CLK_EN |=> reg_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    chk_cfg_readback: assert property (
        reg_rd_in && reg_addr_in < 5'h08 |=> reg_rdata_out == cfg_q[$past(reg_addr_in[2:0])])
        else $error("config word readback wrong");
    chk_data_readback: assert property (
        reg_rd_in && reg_addr_in == `ADR_DATA0 |=> reg_rdata_out == {8'h00, data0_q})
        else $error("data register changed by the datapath");
    chk_mask_readback: assert property (
        reg_rd_in && reg_addr_in == `ADR_MASK |=> reg_rdata_out == {8'h00, mask_q})
        else $error("mask readback wrong");
    chk_clken_readback: assert property (
        reg_rd_in && reg_addr_in == `ADR_CLK_EN |=> reg_rdata_out == {14'h0000, clk_en_q})
        else $error("clock enable readback wrong");
    chk_ctrl_follow: assert property (
        $changed(ctrl_out) |-> ctrl_out == ctrl_q || ctrl_out == $past(ctrl_q))
        else $error("control output not the written value");
    chk_ctrl_hold: assert property (!clk_en_q[1] [*3] |-> $stable(ctrl_out))
        else $error("control output moved while its clock was off");

    cover property (reg_rd_in && reg_addr_in < 5'h08);
    cover property ($changed(ctrl_out));
    cover property (reg_rd_in && reg_addr_in > `ADR_CLK_EN);
endmodule // datapath_checker

bind byte_datapath datapath_checker u_checker (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .ctrl_out(ctrl_out)
);
`default_nettype wire

/* verification/fabric_model.sv */
// routing fabric partner: config address, serial data and chain lines
// assumes the bench picks the address; all lines move after a clock edge
`timescale 1ns/100ps
`default_nettype none
module fabric_model (
    input wire logic core_clk_in,
    input wire logic [2:0] sel_in,
    output logic [5:0] fabric_out,
    output logic carry_out,
    output logic shift_out,
    output logic cond_out
);
    // ********************************************
    // sequencer and neighbour lines
    // ********************************************
    logic [2:0] cnt_q = 3'h0;

    // serial lines toggle only on the idle slot so slot results stay predictable
    always @(posedge core_clk_in) begin
        cnt_q <= cnt_q + 3'h1;
        fabric_out <= {cnt_q[1:0], (sel_in == 3'h0) & cnt_q[2], sel_in};
        carry_out <= cnt_q[0];
        shift_out <= (sel_in == 3'h0) & cnt_q[1];
        cond_out <= cnt_q[2];
    end
endmodule // fabric_model
`default_nettype wire

/* verification/byte_datapath_test.sv */
// self-checking bench for the byte datapath tile
// assumes the fabric model on the config lines and a 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "byte_datapath_defines.vh"
module byte_datapath_test;
    logic core_clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [4:0] reg_addr_in = 5'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [2:0] sel_q = 3'h0;
    wire [15:0] reg_rdata_out;
    wire [5:0] fabric_in;
    wire [5:0] fabric_out;
    wire carry_w;
    wire shift_w;
    wire cond_w;
    wire [7:0] ctrl_out;
    int error_cnt = 0;
    int checked = 0;
    // accumulator one = f(acc0 5a, data0 3c) for each op, then shifts
    logic [15:0] words [0:10] = '{16'h0220, 16'h0221, 16'h0222, 16'h0223, 16'h0224,
        16'h0225, 16'h0226, 16'h0227, 16'h0260, 16'h02a0, 16'h02e0};
    logic [7:0] exps [0:10] = '{8'h5a, 8'h5b, 8'h59, 8'h96, 8'h1e, 8'h18, 8'h7e,
        8'h66, 8'hb4, 8'h2d, 8'ha5};

    // ********************************************
    // clock, design and fabric partner
    // ********************************************
    always #2.5 core_clk_in = ~core_clk_in;

    byte_datapath DUT (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .fabric_in(fabric_in),
        .fabric_out(fabric_out),
        .chain_carry_in(carry_w),
        .chain_shift_in(shift_w),
        .chain_cond_in(cond_w),
        .chain_carry_out(),
        .chain_shift_out(),
        .chain_cond_out(),
        .ctrl_out(ctrl_out)
    );

    fabric_model u_fabric (
        .core_clk_in(core_clk_in),
        .sel_in(sel_q),
        .fabric_out(fabric_in),
        .carry_out(carry_w),
        .shift_out(shift_w),
        .cond_out(cond_w)
    );

    task automatic check(input logic [15:0] act, input logic [15:0] exp);
        checked++;
        if (act !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    // strobes rise after one edge and drop after the edge that takes them
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        check(reg_rdata_out, exp);
    endtask

    // run one config word from slot n long enough to cover the input sync lag
    task automatic run_slot(input logic [2:0] n, input logic [15:0] word);
        wr({2'h0, n}, word);
        sel_q <= n;
        repeat (8) @(posedge core_clk_in);
        sel_q <= 3'h0;
        repeat (6) @(posedge core_clk_in);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ********************************************
    // test sequence
    // ********************************************
    initial begin
        repeat (8) @(posedge core_clk_in);
        arst_n_in <= 1'b1;
        rd(`ADR_MSB, 16'h0007);
        rd(`ADR_MASK, 16'h00ff);
        rd(`ADR_CMP_MASK0, 16'h00ff);
        rd(`ADR_CMP_MASK1, 16'h00ff);
        rd(`ADR_CLK_EN, 16'h0003);
        rd(5'h1f, 16'h0000);
        wr(5'h07, 16'hbeef);
        rd(5'h07, 16'hbeef);
        wr(`ADR_ACC0, 16'h005a);
        wr(`ADR_DATA0, 16'h003c);
        for (int i = 0; i < 11; i++) begin
            run_slot(3'h1, words[i]);
            rd(`ADR_ACC1, {8'h00, exps[i]});
        end
        wr(`ADR_MASK, 16'h000f);
        run_slot(3'h1, 16'h0600);
        rd(`ADR_ACC1, 16'h00fa);
        wr(`ADR_MASK, 16'h00ff);
        // datapath clock off: an increment must leave the accumulator alone
        wr(`ADR_CLK_EN, 16'h0002);
        run_slot(3'h1, 16'h0201);
        rd(`ADR_ACC1, 16'h00fa);
        wr(`ADR_CLK_EN, 16'h0003);
        rd(`ADR_DATA0, 16'h003c);
        // fabric bit 0 shows fifo zero full, bit 1 shows it empty
        wr(`ADR_OUT_SEL, 16'h0035);
        repeat (4) @(posedge core_clk_in);
        check({14'h0000, fabric_out[1:0]}, 16'h0002);
        for (int i = 0; i < 4; i++)
            wr(`ADR_FIFO0, 16'h0010 + 16'(i));
        repeat (4) @(posedge core_clk_in);
        check({14'h0000, fabric_out[1:0]}, 16'h0001);
        run_slot(3'h2, 16'h8300);
        check({14'h0000, fabric_out[1:0]}, 16'h0002);
        wr(`ADR_CTRL, 16'h00a5);
        repeat (3) @(posedge core_clk_in);
        check({8'h00, ctrl_out}, 16'h00a5);
        wr(`ADR_CLK_EN, 16'h0001);
        wr(`ADR_CTRL, 16'h003c);
        repeat (3) @(posedge core_clk_in);
        check({8'h00, ctrl_out}, 16'h00a5);
        wr(`ADR_CLK_EN, 16'h0003);
        repeat (3) @(posedge core_clk_in);
        check({8'h00, ctrl_out}, 16'h003c);
        // history: cmp0, eq1, zero, ovf, full, empty; then only live lt0 and empty
        rd(`ADR_STICKY, 16'h0077);
        rd(`ADR_STICKY, 16'h0041);
        close_out;
    end

    // whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk_in);
        error_cnt++;
        close_out;
    end
endmodule // byte_datapath_test
`default_nettype wire
